// >>> design/hss_homing_search_sequencer.sv
// Contract
// - High-speed segments use switch search speed, low-speed ones fine search speed.
// - Method 1, negative overtravel off: fast reverse, slow forward, index after fall.
// - Method 1, negative overtravel on: slow forward, index after its fall.
// - Method 2, positive overtravel off: fast forward, slow reverse, index after fall.
// - Method 2, positive overtravel on: slow reverse, index after its fall.
// - Method 3, home off: fast forward, slow reverse at rise, index after fall.
// - Method 3, home on: slow reverse, index after home fall.
// - Method 4, home off: fast forward, slow reverse, forward at fall, index after rise.
// - Method 4, home on: slow reverse, forward at fall, index after next rise.
// - Method 5, home off: fast reverse, slow forward at rise, index after fall.
// - Method 5, home on: slow forward, index after home fall.
// - Method 6, home off: fast reverse, slow forward, slow reverse, index after rise.
// - Method 6, home on: slow forward, slow reverse at fall, index after rise.
// - Method 7, no overtravel hit: fast forward, slow reverse, index after fall.
// - Method 7, overtravel hit: reverse fast, slow, forward, reverse, index after fall.
// - Method 7, home on: slow reverse, index after home fall.
// - Method 8, no hit: fast forward, slow reverse, slow forward, index after rise.
// - Method 8, hit: fast reverse, slow reverse, slow forward, index after rise.
// - Method 8, home on: slow reverse, forward at fall, index after rise.
// - Method 9, no hit: fast forward, slow forward, slow reverse, index after rise.
// - Method 9, hit: reverse, slow forward at rise, slow reverse, index after rise.
// - Method 9, home on: slow forward, reverse at fall, index after rise.
// - Homing not finished within a nonzero limit of 100 ms units raises timeout fault; a limit of 0 disables it.
// - On completion position is offset, or feedback plus offset, per calc method.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps

module hss_homing_search_sequencer
  import hss_pkg::*;
#(
  parameter int unsigned TICK_CYC = TIMEOUT_UNIT_CYC
)(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  input  wire hss_pins_t         i_pins,
  input  wire logic [31:0]       i_feedback_pos,
  input  wire logic              i_motor_stopped,
  output logic                   o_move_en,
  output logic                   o_dir_fwd,
  output logic [31:0]            o_speed_cmd,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_homing_timeout_fault,
  output logic [31:0]            o_actual_position_value
);

  localparam int TW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic [3:0]  prev;
    hss_state_t  state;
    logic [1:0]  phase;
    logic        hit;
    logic [7:0]  homing_method_code;
    logic [31:0] switch_search_speed;
    logic [31:0] fine_search_speed;
    logic [15:0] time_limit;
    logic        position_calc_method;
    logic [31:0] home_offset_value;
    logic        busy;
    logic        done;
    logic        fault;
    logic        badm;
    logic [TW-1:0] tick;
    logic [15:0] units;
    logic        move;
    logic        fwd;
    logic [31:0] speed;
    logic [31:0] act_pos;
    logic [31:0] rdata;
  } hss_regs_t;

  hss_regs_t s_ff;
  hss_regs_t nxt_s;

  function automatic hss_step_t mk(input logic fwd, input logic fast, input logic [1:0] pin,
                                   input logic rise, input logic last);
    return {fwd, fast, pin, rise, last};
  endfunction : mk

  // Phase 0 is the fast search; a start with the switch already active skips it.
  function automatic hss_step_t step_of(input logic [7:0] m, input logic hit, input logic [1:0] ph);
    hss_step_t r;
    r = mk(1'b1, 1'b0, PIN_HOME, 1'b0, 1'b1);
    case (m)
      8'h01:
      begin
        if (ph == 2'h0) r = mk(1'b0, 1'b1, PIN_NEG, 1'b1, 1'b0);
        else            r = mk(1'b1, 1'b0, PIN_NEG, 1'b0, 1'b1);
      end
      8'h02:
      begin
        if (ph == 2'h0) r = mk(1'b1, 1'b1, PIN_POS, 1'b1, 1'b0);
        else            r = mk(1'b0, 1'b0, PIN_POS, 1'b0, 1'b1);
      end
      8'h03:
      begin
        if (ph == 2'h0) r = mk(1'b1, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else            r = mk(1'b0, 1'b0, PIN_HOME, 1'b0, 1'b1);
      end
      8'h04:
      begin
        if (ph == 2'h0)      r = mk(1'b1, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else if (ph == 2'h1) r = mk(1'b0, 1'b0, PIN_HOME, 1'b0, 1'b0);
        else                 r = mk(1'b1, 1'b0, PIN_HOME, 1'b1, 1'b1);
      end
      8'h05:
      begin
        if (ph == 2'h0) r = mk(1'b0, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else            r = mk(1'b1, 1'b0, PIN_HOME, 1'b0, 1'b1);
      end
      8'h06:
      begin
        if (ph == 2'h0)      r = mk(1'b0, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else if (ph == 2'h1) r = mk(1'b1, 1'b0, PIN_HOME, 1'b0, 1'b0);
        else                 r = mk(1'b0, 1'b0, PIN_HOME, 1'b1, 1'b1);
      end
      8'h07:
      begin
        if (hit)
        begin
          if (ph == 2'h0)      r = mk(1'b0, 1'b1, PIN_HOME, 1'b1, 1'b0);
          else if (ph == 2'h1) r = mk(1'b0, 1'b0, PIN_HOME, 1'b0, 1'b0);
          else if (ph == 2'h2) r = mk(1'b1, 1'b0, PIN_HOME, 1'b1, 1'b0);
          else                 r = mk(1'b0, 1'b0, PIN_HOME, 1'b0, 1'b1);
        end
        else if (ph == 2'h0) r = mk(1'b1, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else                 r = mk(1'b0, 1'b0, PIN_HOME, 1'b0, 1'b1);
      end
      8'h08:
      begin
        if (hit && ph == 2'h0) r = mk(1'b0, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else if (ph == 2'h0)   r = mk(1'b1, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else if (ph == 2'h1)   r = mk(1'b0, 1'b0, PIN_HOME, 1'b0, 1'b0);
        else                   r = mk(1'b1, 1'b0, PIN_HOME, 1'b1, 1'b1);
      end
      8'h09:
      begin
        if (hit && ph == 2'h0) r = mk(1'b0, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else if (ph == 2'h0)   r = mk(1'b1, 1'b1, PIN_HOME, 1'b1, 1'b0);
        else if (ph == 2'h1)   r = mk(1'b1, 1'b0, PIN_HOME, 1'b0, 1'b0);
        else                   r = mk(1'b0, 1'b0, PIN_HOME, 1'b1, 1'b1);
      end
      default: r = mk(1'b1, 1'b0, PIN_HOME, 1'b0, 1'b1);
    endcase
    return r;
  endfunction : step_of

  logic [3:0] rise_v;
  logic [3:0] fall_v;
  hss_step_t  cur;
  hss_step_t  nstep;
  logic       start_req;
  logic       abort_req;
  logic       timed_out;
  logic       seg_edge;
  logic       ot_hit;
  logic [1:0] start_pin;

  always_comb
  begin
    nxt_s = s_ff;
    // Only the second stage reads the first; edges come from registered samples.
    nxt_s.sy1   = i_pins;
    nxt_s.sy2   = s_ff.sy1;
    nxt_s.prev  = s_ff.sy2;
    nxt_s.rdata = 32'h0;
    rise_v = s_ff.sy2 & ~s_ff.prev;
    fall_v = ~s_ff.sy2 & s_ff.prev;
    cur       = step_of(s_ff.homing_method_code, s_ff.hit, s_ff.phase);
    start_req = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_START_BIT] && !i_wdata[CTRL_ABORT_BIT];
    abort_req = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_ABORT_BIT];
    timed_out = (s_ff.time_limit != 16'h0) && (s_ff.units >= s_ff.time_limit);
    seg_edge  = cur.rise ? rise_v[cur.pin] : fall_v[cur.pin];
    ot_hit    = (s_ff.homing_method_code >= METHOD_OT_HIT) && !s_ff.hit && (s_ff.phase == 2'h0) &&
                rise_v[PIN_POS];
    start_pin = (s_ff.homing_method_code == METHOD_NEG_OT) ? PIN_NEG :
                (s_ff.homing_method_code == METHOD_POS_OT) ? PIN_POS : PIN_HOME;

    // Method and calculation choice are frozen while a search runs.
    if (i_wr)
    begin
      case (i_addr)
        REG_METHOD:      if (!s_ff.busy) nxt_s.homing_method_code = i_wdata[7:0];
        REG_SW_SPEED:    nxt_s.switch_search_speed = i_wdata;
        REG_FINE_SPEED:  nxt_s.fine_search_speed = i_wdata;
        REG_TIME_LIMIT:  nxt_s.time_limit = i_wdata[15:0];
        REG_CALC_METHOD: if (!s_ff.busy) nxt_s.position_calc_method = i_wdata[0];
        REG_HOME_OFFSET: nxt_s.home_offset_value = i_wdata;
        default:         nxt_s.rdata = 32'h0;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        REG_METHOD:      nxt_s.rdata = {24'h0, s_ff.homing_method_code};
        REG_SW_SPEED:    nxt_s.rdata = s_ff.switch_search_speed;
        REG_FINE_SPEED:  nxt_s.rdata = s_ff.fine_search_speed;
        REG_TIME_LIMIT:  nxt_s.rdata = {16'h0, s_ff.time_limit};
        REG_CALC_METHOD: nxt_s.rdata = {31'h0, s_ff.position_calc_method};
        REG_HOME_OFFSET: nxt_s.rdata = s_ff.home_offset_value;
        REG_STATUS:
        begin
          nxt_s.rdata[STAT_BUSY_BIT]  = s_ff.busy;
          nxt_s.rdata[STAT_DONE_BIT]  = s_ff.done;
          nxt_s.rdata[STAT_FAULT_BIT] = s_ff.fault;
          nxt_s.rdata[STAT_BADM_BIT]  = s_ff.badm;
        end
        REG_ACT_POS:     nxt_s.rdata = s_ff.act_pos;
        default:         nxt_s.rdata = 32'h0;
      endcase
    end

    // The time limit is counted in whole units from the accepted start.
    if (s_ff.busy)
    begin
      nxt_s.tick  = (s_ff.tick == TW'(TICK_CYC - 1)) ? '0 : s_ff.tick + TW'(1);
      nxt_s.units = (s_ff.tick == TW'(TICK_CYC - 1)) ? s_ff.units + 16'h1 : s_ff.units;
    end

    case (s_ff.state)
      ST_IDLE:
      begin
        if (start_req)
        begin
          nxt_s.done  = 1'b0;
          nxt_s.fault = 1'b0;
          if (s_ff.homing_method_code >= METHOD_MIN && s_ff.homing_method_code <= METHOD_MAX)
          begin
            nxt_s.badm  = 1'b0;
            nxt_s.busy  = 1'b1;
            nxt_s.hit   = 1'b0;
            nxt_s.tick  = '0;
            nxt_s.units = 16'h0;
            nxt_s.phase = s_ff.sy2[start_pin] ? 2'h1 : 2'h0;
            nxt_s.state = ST_SEEK;
          end
          else
            nxt_s.badm = 1'b1;
        end
      end
      ST_SEEK:
      begin
        if (ot_hit)
          nxt_s.hit = 1'b1;
        else if (seg_edge && cur.last)
          nxt_s.state = ST_INDEX;
        else if (seg_edge)
          nxt_s.phase = s_ff.phase + 2'h1;
      end
      ST_INDEX: if (rise_v[PIN_IDX]) nxt_s.state = ST_STOP;
      ST_STOP:
      begin
        if (i_motor_stopped)
        begin
          nxt_s.done  = 1'b1;
          nxt_s.busy  = 1'b0;
          nxt_s.state = ST_IDLE;
          nxt_s.act_pos = s_ff.position_calc_method ? i_feedback_pos + s_ff.home_offset_value :
                                                      s_ff.home_offset_value;
        end
      end
      default: nxt_s.state = ST_IDLE;
    endcase

    // Timeout and abort override every step of a running search.
    if (s_ff.busy && (timed_out || abort_req))
    begin
      nxt_s.fault = timed_out;
      nxt_s.busy  = 1'b0;
      nxt_s.done  = 1'b0;
      nxt_s.state = ST_IDLE;
    end

    nstep      = step_of(nxt_s.homing_method_code, nxt_s.hit, nxt_s.phase);
    nxt_s.move = (nxt_s.state == ST_SEEK) || (nxt_s.state == ST_INDEX);
    if (nxt_s.move)
      nxt_s.fwd = nstep.fwd;
    nxt_s.speed = nxt_s.move ? (nstep.fast ? nxt_s.switch_search_speed : nxt_s.fine_search_speed) : 32'h0;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_ff                      <= '0;
      s_ff.state                <= ST_IDLE;
      s_ff.homing_method_code   <= METHOD_RST;
      s_ff.switch_search_speed  <= SPEED_RST;
      s_ff.fine_search_speed    <= SPEED_RST;
      s_ff.time_limit           <= TIME_LIMIT_RST;
      s_ff.home_offset_value    <= OFFSET_RST;
      s_ff.fwd                  <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign o_rdata                 = s_ff.rdata;
  assign o_move_en               = s_ff.move;
  assign o_dir_fwd               = s_ff.fwd;
  assign o_speed_cmd             = s_ff.speed;
  assign o_busy                  = s_ff.busy;
  assign o_done                  = s_ff.done;
  assign o_homing_timeout_fault  = s_ff.fault;
  assign o_actual_position_value = s_ff.act_pos;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  sequence seq_start(logic [7:0] m, logic [1:0] p, logic lvl);
    s_ff.state == ST_IDLE && start_req && s_ff.homing_method_code == m && s_ff.sy2[p] == lvl;
  endsequence

  property p_speed_sel;
    o_move_en && s_ff.state == ST_SEEK && cur.fast |-> o_speed_cmd == s_ff.switch_search_speed;
  endproperty
  a_speed_sel: assert property (p_speed_sel) else $error("fast segment not at switch search speed");
  property p_m1_inactive;
    seq_start(8'h01, PIN_NEG, 1'b0) |=> o_move_en && !o_dir_fwd && o_speed_cmd == s_ff.switch_search_speed;
  endproperty
  a_m1_inactive: assert property (p_m1_inactive) else $error("method 1 did not start fast reverse");
  property p_m1_active;
    seq_start(8'h01, PIN_NEG, 1'b1) |=> o_move_en && o_dir_fwd && o_speed_cmd == s_ff.fine_search_speed;
  endproperty
  a_m1_active: assert property (p_m1_active) else $error("method 1 did not start slow forward");
  property p_m2_inactive;
    seq_start(8'h02, PIN_POS, 1'b0) |=> o_move_en && o_dir_fwd && o_speed_cmd == s_ff.switch_search_speed;
  endproperty
  a_m2_inactive: assert property (p_m2_inactive) else $error("method 2 did not start fast forward");
  property p_m7_hit;
    s_ff.state == ST_SEEK && ot_hit && !timed_out && !abort_req |=>
      !o_dir_fwd && o_speed_cmd == s_ff.switch_search_speed;
  endproperty
  a_m7_hit: assert property (p_m7_hit) else $error("overtravel hit did not turn to fast reverse");
  property p_index_stop;
    s_ff.state == ST_INDEX && rise_v[PIN_IDX] && !timed_out && !abort_req |=> !o_move_en ##1 !o_move_en;
  endproperty
  a_index_stop: assert property (p_index_stop) else $error("motion kept after qualifying index");
  property p_timeout;
    s_ff.busy && timed_out |=> o_homing_timeout_fault && !o_busy && !o_move_en && !o_done;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time limit passed without fault");
  property p_abs_pos;
    s_ff.state == ST_STOP && i_motor_stopped && !timed_out && !abort_req && !s_ff.position_calc_method |=>
      o_done && o_actual_position_value == $past(s_ff.home_offset_value);
  endproperty
  a_abs_pos: assert property (p_abs_pos) else $error("absolute home position wrong");
  property p_rel_pos;
    s_ff.state == ST_STOP && i_motor_stopped && !timed_out && !abort_req && s_ff.position_calc_method |=>
      o_actual_position_value == $past(i_feedback_pos) + $past(s_ff.home_offset_value);
  endproperty
  a_rel_pos: assert property (p_rel_pos) else $error("relative home position wrong");

endmodule : hss_homing_search_sequencer

// >>> inc/hss_pkg.sv
package hss_pkg;

  // Timing base for the homing time limit.
  localparam int CLK_FREQ_KHZ     = 250000;
  localparam int TIMEOUT_UNIT_MS  = 100;
  localparam int TIMEOUT_UNIT_CYC = TIMEOUT_UNIT_MS * CLK_FREQ_KHZ;

  // Register index map on the plain register port.
  localparam int         ADDR_W          = 4;
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_METHOD      = 4'h1;
  localparam logic [3:0] REG_SW_SPEED    = 4'h2;
  localparam logic [3:0] REG_FINE_SPEED  = 4'h3;
  localparam logic [3:0] REG_TIME_LIMIT  = 4'h4;
  localparam logic [3:0] REG_CALC_METHOD = 4'h5;
  localparam logic [3:0] REG_HOME_OFFSET = 4'h6;
  localparam logic [3:0] REG_STATUS      = 4'h7;
  localparam logic [3:0] REG_ACT_POS     = 4'h8;

  // Control and status field positions.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_BADM_BIT  = 3;

  // Reset values.
  localparam logic [7:0]  METHOD_RST     = 8'h01;
  localparam logic [31:0] SPEED_RST      = 32'h0;
  localparam logic [15:0] TIME_LIMIT_RST = 16'hc350;
  localparam logic [31:0] OFFSET_RST     = 32'h0;

  // Method codes with special handling.
  localparam logic [7:0] METHOD_MIN     = 8'h01;
  localparam logic [7:0] METHOD_MAX     = 8'h09;
  localparam logic [7:0] METHOD_NEG_OT  = 8'h01;
  localparam logic [7:0] METHOD_POS_OT  = 8'h02;
  localparam logic [7:0] METHOD_OT_HIT  = 8'h07;

  // Bit positions of the pin carrier.
  localparam logic [1:0] PIN_NEG  = 2'h3;
  localparam logic [1:0] PIN_POS  = 2'h2;
  localparam logic [1:0] PIN_HOME = 2'h1;
  localparam logic [1:0] PIN_IDX  = 2'h0;

  typedef struct packed {
    logic negative_overtravel_input;
    logic positive_overtravel_input;
    logic home_switch_input;
    logic index_pulse;
  } hss_pins_t;

  typedef struct packed {
    logic       fwd;
    logic       fast;
    logic [1:0] pin;
    logic       rise;
    logic       last;
  } hss_step_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEEK,
    ST_INDEX,
    ST_STOP
  } hss_state_t;

endpackage : hss_pkg

// >>> tb/hss_axis_model.sv
`timescale 1ns/1ps

// Behavioural axis: position moves two units a cycle at search speed and one unit at fine speed.
// Switch windows are kept well clear of index marks, so three cycles of input sync delay never
// shift which index pulse qualifies.
module hss_axis_model
  import hss_pkg::*;
#(
  parameter logic [31:0] NEG_LIM  = 32'h64,
  parameter logic [31:0] POS_LIM  = 32'h3a2,
  parameter logic [31:0] HOME_LO  = 32'h1e0,
  parameter logic [31:0] HOME_HI  = 32'h208,
  parameter logic [31:0] FAST_MIN = 32'h80
)(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_move_en,
  input  wire logic        i_dir_fwd,
  input  wire logic [31:0] i_speed_cmd,
  input  wire logic        i_load,
  input  wire logic [31:0] i_load_pos,
  output hss_pins_t        o_pins,
  output logic [31:0]      o_feedback_pos,
  output logic             o_motor_stopped
);

  logic [31:0] pos_ff;
  logic [31:0] step;
  logic [1:0]  idle_ff;

  assign step = (i_speed_cmd >= FAST_MIN) ? 32'h2 : 32'h1;

  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pos_ff  <= 32'h0;
      idle_ff <= 2'h0;
    end
    else
    begin
      idle_ff <= {idle_ff[0], ~i_move_en};
      if (i_load)
        pos_ff <= i_load_pos;
      else if (i_move_en)
        pos_ff <= i_dir_fwd ? pos_ff + step : pos_ff - step;
    end
  end

  // Index marks every 64 units, two units wide so a fine-speed pass always shows a pulse.
  assign o_pins = {pos_ff <= NEG_LIM, pos_ff >= POS_LIM,
                   (pos_ff >= HOME_LO) && (pos_ff <= HOME_HI), pos_ff[5:0] < 6'h2};
  assign o_feedback_pos  = pos_ff;
  assign o_motor_stopped = &idle_ff;

endmodule : hss_axis_model

// >>> tb/test_homing_search_sequencer.sv
`timescale 1ns/1ps

module test_homing_search_sequencer;
  import hss_pkg::*;

  localparam logic [31:0] SW_SPD   = 32'h100;
  localparam logic [31:0] FINE_SPD = 32'h10;
  localparam int          LIMIT    = 60000;

  logic              i_clk_sys = 1'b0;
  logic              i_rstn    = 1'b0;
  logic [ADDR_W-1:0] i_addr    = '0;
  logic [31:0]       i_wdata   = '0;
  logic              i_wr      = 1'b0;
  logic              i_rd      = 1'b0;
  logic              load      = 1'b0;
  logic [31:0]       load_pos  = '0;
  hss_pins_t         pins;
  logic [31:0]       fb_pos, o_rdata, o_speed_cmd, o_actual_position_value, rdat;
  logic              stopped, o_move_en, o_dir_fwd, o_busy, o_done, o_homing_timeout_fault;
  logic [19:0]       rec = '0;
  int                bad_count = 0;
  int                comparisons = 0;
  int                cycles = 0;
  int                k;

  // Each row: method, start position, expected segment codes, index mark to stop on.
  // Segment code: 4 reverse fine, 5 reverse fast, 6 forward fine, 7 forward fast.
  logic [47:0] tab [21] = '{
    48'h1_12c_00056_080, 48'h1_032_00006_080,
    48'h2_2bc_00074_380, 48'h2_3b6_00004_380,
    48'h3_12c_00074_1c0, 48'h3_1f4_00004_1c0,
    48'h4_12c_00746_200, 48'h4_1f4_00046_200,
    48'h5_2bc_00056_240, 48'h5_1f4_00006_240,
    48'h6_2bc_00564_200, 48'h6_1f4_00064_200,
    48'h7_12c_00074_1c0, 48'h7_212_75464_1c0, 48'h7_1f4_00004_1c0,
    48'h8_12c_00746_200, 48'h8_212_07546_200, 48'h8_1f4_00046_200,
    48'h9_12c_00764_200, 48'h9_212_07564_200, 48'h9_1f4_00064_200};

  hss_homing_search_sequencer #(.TICK_CYC(10)) uut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pins(pins), .i_feedback_pos(fb_pos),
    .i_motor_stopped(stopped), .o_move_en(o_move_en), .o_dir_fwd(o_dir_fwd),
    .o_speed_cmd(o_speed_cmd), .o_busy(o_busy), .o_done(o_done),
    .o_homing_timeout_fault(o_homing_timeout_fault), .o_actual_position_value(o_actual_position_value));

  hss_axis_model axis (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_move_en(o_move_en), .i_dir_fwd(o_dir_fwd),
    .i_speed_cmd(o_speed_cmd), .i_load(load), .i_load_pos(load_pos), .o_pins(pins),
    .o_feedback_pos(fb_pos), .o_motor_stopped(stopped));

  always #2 i_clk_sys = ~i_clk_sys;

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  task automatic place(input logic [31:0] p, input logic [3:0] m);
    @(posedge i_clk_sys);
    load     <= 1'b1;
    load_pos <= p;
    @(posedge i_clk_sys);
    load     <= 1'b0;
    cyc(6);
    wr(REG_METHOD, {28'h0, m});
  endtask : place

  task automatic home_run(input logic [47:0] r, input logic calc);
    logic [31:0] off;
    off = {28'h0, r[47:44]} + 32'h10000;
    place({20'h0, r[43:32]}, r[47:44]);
    wr(REG_CALC_METHOD, {31'h0, calc});
    wr(REG_HOME_OFFSET, off);
    wr(REG_CTRL, 32'h1);
    cyc(2);
    k = 0;
    while (o_done !== 1'b1 && k < 4000)
    begin
      @(posedge i_clk_sys);
      k++;
    end
    #1;
    chk({31'h0, o_done}, 32'h1);
    chk({12'h0, rec}, {12'h0, r[31:12]});
    chk({31'h0, (fb_pos + 32'h8 - {20'h0, r[11:0]}) <= 32'h10}, 32'h1);
    chk(o_actual_position_value, calc ? fb_pos + off : off);
    chk({31'h0, o_busy}, 32'h0);
  endtask : home_run

  // Segment recorder and speed watch run on every cycle of motion.
  always @(posedge i_clk_sys)
  begin
    cycles <= cycles + 1;
    if (o_busy === 1'b1 && o_move_en === 1'b1)
    begin
      chk(o_speed_cmd, (o_speed_cmd === SW_SPD) ? SW_SPD : FINE_SPD);
      if ({2'b01, o_dir_fwd, o_speed_cmd === SW_SPD} !== rec[3:0])
        rec <= {rec[15:0], 2'b01, o_dir_fwd, o_speed_cmd === SW_SPD};
    end
    // The recorder alone owns rec; a control write starts a fresh record.
    if (i_wr === 1'b1 && i_addr == REG_CTRL)
      rec <= '0;
    if (cycles == LIMIT)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    cyc(8);
    i_rstn <= 1'b1;
    cyc(4);
    rd(REG_METHOD, rdat);
    chk(rdat, {24'h0, METHOD_RST});
    rd(REG_TIME_LIMIT, rdat);
    chk(rdat, {16'h0, TIME_LIMIT_RST});
    rd(REG_SW_SPEED, rdat);
    chk(rdat, SPEED_RST);
    rd(4'hf, rdat);
    chk(rdat, 32'h0);
    wr(REG_SW_SPEED, SW_SPD);
    wr(REG_FINE_SPEED, FINE_SPD);
    rd(REG_FINE_SPEED, rdat);
    chk(rdat, FINE_SPD);
    for (int i = 0; i < 21; i++)
      home_run(tab[i], i[0]);
    // Method locked while busy, then abort halts without a fault.
    place(32'h12c, 4'h3);
    wr(REG_CTRL, 32'h1);
    wr(REG_METHOD, 32'h9);
    rd(REG_METHOD, rdat);
    chk(rdat, 32'h3);
    rd(REG_STATUS, rdat);
    chk(rdat, 32'h1);
    wr(REG_CTRL, 32'h2);
    cyc(2);
    chk({o_move_en, o_busy, o_homing_timeout_fault}, 32'h0);
    // Limit of two 10-cycle units runs out long before the home switch is reached.
    wr(REG_TIME_LIMIT, 32'h2);
    place(32'h12c, 4'h3);
    wr(REG_CTRL, 32'h1);
    cyc(15);
    chk({31'h0, o_homing_timeout_fault}, 32'h0);
    cyc(15);
    chk({o_homing_timeout_fault, o_move_en}, 32'h2);
    rd(REG_STATUS, rdat);
    chk(rdat & 32'h4, 32'h4);
    wr(REG_TIME_LIMIT, {16'h0, TIME_LIMIT_RST});
    place(32'h12c, 4'h0);
    wr(REG_CTRL, 32'h1);
    cyc(2);
    rd(REG_STATUS, rdat);
    chk(rdat, 32'h8);
    conclude();
  end

endmodule : test_homing_search_sequencer
